// ### logic/lst_cfg.svh
`ifndef LST_CFG_SVH
`define LST_CFG_SVH
// How it works
// - sync bit 3 set (default) selects automatic sync
// - auto sync loads new image at cycle end
// - manual sync aborts cycle, shows image now
// - clock reverse drives inverted forwarded clock
// - link config bit 2 enables time-out
// - bits 1:0 choose the time-out window
// - time-out discards partial packet, keeps image
// - after time-out, hunt for a packet header

// ==================== link words
`define LST_WORD_W 16
`define LST_PKT_WORDS 3
`define LST_HDR_IMG 16'hd3a0
`define LST_HDR_CFG 16'hd3c0

// ==================== configuration banks
`define LST_MAIN_W 10
`define LST_MAIN_RST 10'h27e
`define LST_SYNC_BIT 3
`define LST_REV_HI 2
`define LST_REV_LO 1
`define LST_REV_ON 2'h3
`define LST_LINK_W 3
`define LST_LINK_RST 3'h7
`define LST_TMO_EN_BIT 2

// ==================== time-out in oscillator cycles
`define LST_TMO_W 8
`define LST_TMO_LIM_3 8'd128
`define LST_TMO_LIM_2 8'd64
`define LST_TMO_LIM_1 8'd32
`define LST_TMO_LIM_0 8'd16
`define LST_WIN_MIN_3 8'd95
`define LST_WIN_MAX_3 8'd172
`define LST_WIN_MIN_2 8'd47
`define LST_WIN_MAX_2 8'd86
`define LST_WIN_MIN_1 8'd23
`define LST_WIN_MAX_1 8'd44
`define LST_WIN_MIN_0 8'd11
`define LST_WIN_MAX_0 8'd22

// ==================== structure
`define LST_PWM_W 16
`define LST_FIFO_DEPTH 16
`endif

// ### logic/lst_pkg.sv
`include "lst_cfg.svh"
package lst_pkg;
	typedef enum logic [1:0] {ST_HEADER, ST_BODY, ST_HUNT} lst_rx_state_type;
	typedef struct packed {
		logic abort;
		logic last;
		logic cfg;
		logic [`LST_WORD_W-1:0] data;
	} lst_item_type;
endpackage : lst_pkg

// ### logic/lst_sync2.sv
`timescale 1ns/100ps
module lst_sync2 (
	input wire logic clk_i,  // destination clock
	input wire logic srst_i, // sync reset
	input wire logic d_i,    // asynchronous level
	output logic q_o         // synchronised level
);
	logic meta_r;

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			meta_r <= 1'b0;
			q_o <= 1'b0;
		end else begin
			meta_r <= d_i;
			q_o <= meta_r;
		end
	end
endmodule : lst_sync2

// ### logic/lst_fifo.sv
`timescale 1ns/100ps
module lst_fifo #(
	parameter int WIDTH = 19, // word width
	parameter int DEPTH = 16  // words, power of two
) (
	input wire logic clk_i,              // clock
	input wire logic srst_i,             // sync reset
	input wire logic [WIDTH-1:0] in_data_i, // write word
	input wire logic in_valid_i,         // write request
	output logic in_ready_o,             // room for a word
	output logic [WIDTH-1:0] out_data_o, // head word
	output logic out_valid_o,            // head word present
	input wire logic out_ready_i         // head word taken
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [AW:0] count_r;
	logic wr;
	logic rd;

	assign in_ready_o = (count_r != FULL_CNT);
	assign out_valid_o = (count_r != '0);
	assign out_data_o = mem_r[rd_ptr_r];
	assign wr = in_valid_i && in_ready_o;
	assign rd = out_valid_o && out_ready_i;

	always_ff @(posedge clk_i) begin
		if (wr) begin
			mem_r[wr_ptr_r] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
		end else begin
			if (wr) begin
				wr_ptr_r <= wr_ptr_r + (AW)'(1);
			end
			if (rd) begin
				rd_ptr_r <= rd_ptr_r + (AW)'(1);
			end
			count_r <= count_r + (AW+1)'(wr) - (AW+1)'(rd);
		end
	end

	chk_fifo_bound: assert property (@(posedge clk_i) disable iff (srst_i) count_r <= FULL_CNT)
		else $error("fifo count beyond depth");
	chk_fifo_step: assert property (@(posedge clk_i) disable iff (srst_i)
		(wr && !rd) |=> (count_r == $past(count_r) + (AW+1)'(1)))
		else $error("fifo count did not step on write");
endmodule : lst_fifo

// ### logic/lst_link_sync.sv
`timescale 1ns/100ps
`include "lst_cfg.svh"
module lst_link_sync #(
	parameter int PWM_W = `LST_PWM_W,          // pwm counter width, at most 16
	parameter int FIFO_DEPTH = `LST_FIFO_DEPTH // buffered link words
) (
	input wire logic clk_i,              // oscillator clock, 100 MHz
	input wire logic srst_i,             // sync reset, active high
	input wire logic serial_clock_in_i,  // link clock from upstream
	input wire logic serial_data_in_i,   // link data, taken on rising clock
	output logic serial_clock_out_o,     // forwarded link clock
	output logic serial_data_out_o,      // forwarded link data
	output logic [2:0] pwm_o,            // channel pwm outputs
	output logic packet_ok_o,            // pulse: packet recognised
	output logic packet_drop_o,          // pulse: packet discarded
	output logic overrun_o,              // pulse: buffer full, word lost
	output logic auto_sync_o             // level: automatic sync selected
);
	localparam logic [1:0] LAST_IDX = 2'(`LST_PKT_WORDS - 1);
	localparam logic [PWM_W-1:0] PWM_MAX = {PWM_W{1'b1}};

	// ==================== link clock domain
	logic lbit_r = 1'b0;
	logic ltog_r = 1'b0;

	always_ff @(posedge serial_clock_in_i) begin
		lbit_r <= serial_data_in_i;
		ltog_r <= ~ltog_r;
	end

	logic [`LST_MAIN_W-1:0] main_config_bank_r;
	logic [`LST_LINK_W-1:0] link_timeout_config_r;
	logic auto_sync;
	logic rev_on;
	logic tmo_en;

	assign auto_sync = main_config_bank_r[`LST_SYNC_BIT];
	assign rev_on = (main_config_bank_r[`LST_REV_HI:`LST_REV_LO] == `LST_REV_ON);
	assign tmo_en = link_timeout_config_r[`LST_TMO_EN_BIT];
	assign auto_sync_o = auto_sync;
	assign serial_clock_out_o = rev_on ? ~serial_clock_in_i : serial_clock_in_i;
	assign serial_data_out_o = lbit_r;

	// ==================== crossing into oscillator domain
	logic sclk_s;
	logic tog_s;
	logic tog_d_r;
	logic bit_evt;

	lst_sync2 u_sync_clk (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.d_i(serial_clock_in_i),
		.q_o(sclk_s)
	);

	lst_sync2 u_sync_tog (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.d_i(ltog_r),
		.q_o(tog_s)
	);

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			tog_d_r <= 1'b0;
		end else begin
			tog_d_r <= tog_s;
		end
	end

	// bit held stable for a whole link period, read once the toggle lands
	assign bit_evt = tog_s ^ tog_d_r;

	// ==================== clock-low time-out
	logic [`LST_TMO_W-1:0] low_cnt_r;
	logic [`LST_TMO_W-1:0] tmo_lim;
	logic [`LST_TMO_W-1:0] win_min;
	logic [`LST_TMO_W-1:0] win_max;
	logic tmo_evt;

	always_comb begin
		case (link_timeout_config_r[1:0])
			2'h3: begin
				tmo_lim = `LST_TMO_LIM_3;
				win_min = `LST_WIN_MIN_3;
				win_max = `LST_WIN_MAX_3;
			end
			2'h2: begin
				tmo_lim = `LST_TMO_LIM_2;
				win_min = `LST_WIN_MIN_2;
				win_max = `LST_WIN_MAX_2;
			end
			2'h1: begin
				tmo_lim = `LST_TMO_LIM_1;
				win_min = `LST_WIN_MIN_1;
				win_max = `LST_WIN_MAX_1;
			end
			default: begin
				tmo_lim = `LST_TMO_LIM_0;
				win_min = `LST_WIN_MIN_0;
				win_max = `LST_WIN_MAX_0;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (srst_i || sclk_s) begin
			low_cnt_r <= '0;
		end else if (low_cnt_r != tmo_lim) begin
			low_cnt_r <= low_cnt_r + 8'h01;
		end
	end

	// fires once per low stretch; count saturates at the limit
	assign tmo_evt = tmo_en && !sclk_s && (low_cnt_r == tmo_lim - 8'h01);

	// ==================== packet receiver
	lst_pkg::lst_rx_state_type state_r;
	logic [`LST_WORD_W-1:0] shift_r;
	logic [3:0] bit_cnt_r;
	logic [1:0] word_cnt_r;
	logic kind_cfg_r;
	logic abort_pend_r;
	logic [`LST_WORD_W-1:0] word_in;
	logic word_done;
	logic push_req;
	logic push_ok;
	logic fifo_in_ready;
	logic bad_hdr;
	lst_pkg::lst_item_type push_item;

	assign word_in = {shift_r[`LST_WORD_W-2:0], lbit_r};
	assign word_done = bit_evt && (bit_cnt_r == 4'hf);
	assign push_req = word_done && (state_r == lst_pkg::ST_BODY) && !tmo_evt;
	assign push_ok = fifo_in_ready && !abort_pend_r;
	assign bad_hdr = word_done && !tmo_evt && (state_r == lst_pkg::ST_HEADER) &&
		(word_in != `LST_HDR_IMG) && (word_in != `LST_HDR_CFG);

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			state_r <= lst_pkg::ST_HEADER;
			shift_r <= '0;
			bit_cnt_r <= '0;
			word_cnt_r <= '0;
			kind_cfg_r <= 1'b0;
		end else if (tmo_evt) begin
			state_r <= lst_pkg::ST_HEADER;
			bit_cnt_r <= '0;
			word_cnt_r <= '0;
		end else if (bit_evt) begin
			shift_r <= word_in;
			bit_cnt_r <= bit_cnt_r + 4'h1;
			if (word_done) begin
				case (state_r)
					lst_pkg::ST_HEADER: begin
						if (word_in == `LST_HDR_IMG) begin
							state_r <= lst_pkg::ST_BODY;
							kind_cfg_r <= 1'b0;
						end else if (word_in == `LST_HDR_CFG) begin
							state_r <= lst_pkg::ST_BODY;
							kind_cfg_r <= 1'b1;
						end else begin
							state_r <= lst_pkg::ST_HUNT;
						end
					end
					lst_pkg::ST_BODY: begin
						if (!push_ok) begin
							state_r <= lst_pkg::ST_HUNT;
						end else if (word_cnt_r == LAST_IDX) begin
							state_r <= lst_pkg::ST_HEADER;
							word_cnt_r <= '0;
						end else begin
							word_cnt_r <= word_cnt_r + 2'h1;
						end
					end
					default: begin
						state_r <= lst_pkg::ST_HUNT;
					end
				endcase
			end
		end
	end

	// an abort marker tells the drain side to forget a half packet
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			abort_pend_r <= 1'b0;
		end else if ((tmo_evt && state_r == lst_pkg::ST_BODY && word_cnt_r != '0) ||
			(push_req && !push_ok)) begin
			abort_pend_r <= 1'b1;
		end else if (fifo_in_ready) begin
			abort_pend_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			packet_drop_o <= 1'b0;
			overrun_o <= 1'b0;
		end else begin
			packet_drop_o <= (tmo_evt && (state_r == lst_pkg::ST_BODY || bit_cnt_r != '0)) ||
				bad_hdr || (push_req && !push_ok);
			overrun_o <= push_req && !fifo_in_ready;
		end
	end

	always_comb begin
		push_item = '0;
		if (abort_pend_r) begin
			push_item.abort = 1'b1;
		end else begin
			push_item.last = (word_cnt_r == LAST_IDX);
			push_item.cfg = kind_cfg_r;
			push_item.data = word_in;
		end
	end

	// ==================== word buffer
	lst_pkg::lst_item_type pop_item;
	logic fifo_out_valid;
	logic pop;
	logic pend_valid_r;

	assign pop = fifo_out_valid && !pend_valid_r;

	lst_fifo #(
		.WIDTH($bits(lst_pkg::lst_item_type)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.in_data_i(push_item),
		.in_valid_i(abort_pend_r || push_req),
		.in_ready_o(fifo_in_ready),
		.out_data_o(pop_item),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(pop)
	);

	// ==================== packet assembly and configuration
	logic [`LST_WORD_W-1:0] acc_r [`LST_PKT_WORDS];
	logic [1:0] acc_cnt_r;
	logic complete;
	logic complete_img;
	logic cfg_match;

	assign complete = pop && !pop_item.abort && pop_item.last && (acc_cnt_r == LAST_IDX);
	assign complete_img = complete && !pop_item.cfg;
	assign cfg_match = (acc_r[0][`LST_MAIN_W-1:0] == acc_r[1][`LST_MAIN_W-1:0]);

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			acc_cnt_r <= '0;
		end else if (pop) begin
			if (pop_item.abort || pop_item.last) begin
				acc_cnt_r <= '0;
			end else begin
				acc_cnt_r <= acc_cnt_r + 2'h1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (pop && !pop_item.abort && !pop_item.last) begin
			acc_r[acc_cnt_r] <= pop_item.data;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			main_config_bank_r <= `LST_MAIN_RST;
			link_timeout_config_r <= `LST_LINK_RST;
		end else if (complete && pop_item.cfg && cfg_match) begin
			main_config_bank_r <= acc_r[0][`LST_MAIN_W-1:0];
			link_timeout_config_r <= pop_item.data[`LST_LINK_W-1:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			packet_ok_o <= 1'b0;
		end else begin
			packet_ok_o <= complete && (!pop_item.cfg || cfg_match);
		end
	end

	// ==================== image hand-over and pwm
	logic [2:0][PWM_W-1:0] pend_r;
	logic [2:0][PWM_W-1:0] duty_r;
	logic [PWM_W-1:0] pwm_cnt_r;
	logic img_load;

	assign img_load = pend_valid_r && (!auto_sync || pwm_cnt_r == PWM_MAX);

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			pend_valid_r <= 1'b0;
			pend_r <= '0;
		end else if (img_load) begin
			pend_valid_r <= 1'b0;
		end else if (complete_img) begin
			pend_valid_r <= 1'b1;
			pend_r[0] <= acc_r[0][`LST_WORD_W-1 -: PWM_W];
			pend_r[1] <= acc_r[1][`LST_WORD_W-1 -: PWM_W];
			pend_r[2] <= pop_item.data[`LST_WORD_W-1 -: PWM_W];
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			duty_r <= '0;
		end else if (img_load) begin
			duty_r <= pend_r;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i || img_load) begin
			pwm_cnt_r <= '0;
		end else begin
			pwm_cnt_r <= pwm_cnt_r + PWM_W'(1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			pwm_o <= '0;
		end else begin
			for (int i = 0; i < 3; i++) begin
				pwm_o[i] <= (pwm_cnt_r < duty_r[i]);
			end
		end
	end

	// ==================== checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);

	chk_sync_default: assert property ($fell(srst_i) |-> auto_sync)
		else $error("automatic sync not selected after reset");
	chk_auto_hold: assert property ((pend_valid_r && auto_sync && pwm_cnt_r != PWM_MAX) |=> $stable(duty_r))
		else $error("image replaced before pwm cycle end");
	chk_new_cycle: assert property (img_load |=> (pwm_cnt_r == '0 && duty_r == $past(pend_r)))
		else $error("loaded image did not start a fresh cycle");
	chk_manual_now: assert property ((complete_img && !auto_sync) |=> img_load ##1 (pwm_cnt_r == '0))
		else $error("manual sync did not show new image at once");
	chk_clock_rev: assert property (rev_on |-> (serial_clock_out_o != serial_clock_in_i))
		else $error("forwarded clock not inverted");
	chk_tmo_off: assert property ((!tmo_en && state_r == lst_pkg::ST_HUNT) |=> (state_r == lst_pkg::ST_HUNT || tmo_en))
		else $error("boundary found with time-out disabled");
	chk_tmo_window: assert property (tmo_evt |-> (low_cnt_r >= win_min - 8'h01 && low_cnt_r < win_max))
		else $error("time-out outside selected window");
	chk_drop_partial: assert property ((tmo_evt && state_r == lst_pkg::ST_BODY && word_cnt_r != '0) |=> abort_pend_r ##0 packet_drop_o)
		else $error("partial packet not discarded on time-out");
	chk_header_hunt: assert property (tmo_evt |=> (state_r == lst_pkg::ST_HEADER && bit_cnt_r == '0))
		else $error("receiver not waiting for header after time-out");
endmodule : lst_link_sync

// ### bench/lst_ctrl_model.sv
`timescale 1ns/100ps
module lst_ctrl_model (
	output logic sclk_o, // link clock, low outside frames
	output logic sdata_o // link data, msb first
);
	initial begin
		sclk_o = 1'b0;
		sdata_o = 1'b0;
	end

	// ====================
	// frames
	function automatic logic [47:0] cfg_body(input logic [9:0] m, input logic [9:0] c, input logic [2:0] l);
		return {6'h00, m, 6'h00, c, 13'h0000, l};
	endfunction : cfg_body

	task automatic idle(input int t);
		sdata_o = ~sdata_o; // released line, no keeper
		#(t);
	endtask : idle

	task automatic send_pkt(input logic [15:0] h, input logic [47:0] b, input int nw);
		logic [63:0] f;
		f = {h, b};
		#3.7;
		for (int i = 63; i > 47 - 16 * nw; i--) begin
			sdata_o = f[i];
			#32 sclk_o = 1'b1;
			#32 sclk_o = 1'b0;
		end
		idle(2100);
	endtask : send_pkt
endmodule : lst_ctrl_model

// ### bench/lst_link_sync_tb.sv
`timescale 1ns/100ps
`include "lst_cfg.svh"
module lst_link_sync_tb;
	logic clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic sclk, sdata, clk_out, auto, ok, drop, dout, ovr;
	logic [2:0] pwm;
	logic [31:0] lfsr = 32'hd1e6;
	logic [5:0] last_d = 6'h00;
	logic exp_auto = 1'b1;
	int n_fail = 0;
	int checks = 0;
	int n_ok = 0;
	int cyc = 0;
	int rel = 0;
	int c0 = 0;
	// period of the 6-bit pwm counter of the instance below
	localparam int PWM_P = 64;
	realtime t_fall = 0.0;
	realtime t_drop = 0.0;

	always #5 clk_i = ~clk_i;

	lst_ctrl_model i_ctrl (.sclk_o(sclk), .sdata_o(sdata));
	lst_link_sync #(.PWM_W(6), .FIFO_DEPTH(16)) i_dut (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.serial_clock_in_i(sclk),
		.serial_data_in_i(sdata),
		.serial_clock_out_o(clk_out),
		.serial_data_out_o(dout),
		.pwm_o(pwm),
		.packet_ok_o(ok),
		.packet_drop_o(drop),
		.overrun_o(ovr),
		.auto_sync_o(auto)
	);

	// ====================
	// helpers
	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction : rnd

	function automatic bit in_win(input logic [1:0] c, input int n);
		int lo, hi;
		lo = c == 2'h3 ? 95 : c == 2'h2 ? 47 : c == 2'h1 ? 23 : 11;
		hi = c == 2'h3 ? 172 : c == 2'h2 ? 86 : c == 2'h1 ? 44 : 22;
		return n >= lo && n <= hi;
	endfunction : in_win

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
		end
	endtask : check

	task automatic stop_test();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : stop_test

	always @(negedge sclk) t_fall = $realtime;

	always @(posedge clk_i) begin
		cyc++;
		if (ok === 1'b1) n_ok++;
		if (drop === 1'b1) t_drop = $realtime;
		// configuration bank is unknown until the first reset edge
		if (srst_i === 1'b0) begin
			check(clk_out, {~sclk}, "forwarded clock");
			check(ovr, 1'b0, "no overrun");
		end
	end

	// retimed data follows the bit taken at the rising link clock
	always @(posedge sclk) begin
		#1;
		check(dout, sdata, "forwarded data");
	end

	task automatic wait_pulse(input bit on_drop, input int lim, output int n);
		n = 0;
		do begin
			@(posedge clk_i);
			#1;
			n++;
		end while ((on_drop ? drop : ok) !== 1'b1 && n < lim);
	endtask : wait_pulse

	// first high sample, and length of the first high run that rises in the window
	task automatic pwm_run(output int first, output int run);
		logic prev;
		int start;
		first = -1;
		run = 0;
		start = -1;
		@(posedge clk_i);
		#1;
		prev = pwm[0];
		for (int i = 0; i < 140; i++) begin
			@(posedge clk_i);
			#1;
			if (i == 0) c0 = cyc;
			if (pwm[0] === 1'b1 && first < 0) first = i;
			if (pwm[0] === 1'b1 && prev === 1'b0 && start < 0) start = i;
			if (pwm[0] === 1'b1 && start >= 0 && i == start + run) run++;
			prev = pwm[0];
		end
	endtask : pwm_run

	task automatic xfer(input logic [15:0] h, input logic [47:0] b, input int nw, input bit on_drop,
			input int lim, output int n, output int first, output int run);
		@(posedge clk_i);
		fork
			i_ctrl.send_pkt(h, b, nw);
			begin
				wait_pulse(on_drop, lim, n);
				pwm_run(first, run);
			end
		join
	endtask : xfer

	// ====================
	// scenarios
	task automatic img(input bit manual);
		int n, first, run;
		logic [31:0] r;
		r = rnd();
		last_d = {r[31:27], 1'b1};
		xfer(`LST_HDR_IMG, {last_d, r[25:16], r[15:0], r[31:16]}, 3, 1'b0, 1000, n, first, run);
		check(n < 1000, 1'b1, "image taken");
		if (manual) check(first, 0, "new cycle at once");
		else check(first, (PWM_P - (c0 - rel) % PWM_P) % PWM_P, "load at cycle end");
		check(run, last_d, "duty shown");
	endtask : img

	task automatic cfg(input logic [9:0] m, input logic [9:0] c, input logic [2:0] l);
		int n, first, run;
		xfer(`LST_HDR_CFG, i_ctrl.cfg_body(m, c, l), 3, 1'b0, 700, n, first, run);
		check(n < 700, m == c, "config taken");
		if (m == c) exp_auto = m[3];
		check(auto, exp_auto, "sync mode");
	endtask : cfg

	task automatic tmo(input logic [2:0] l);
		int n, first, run, k;
		cfg(10'h276, 10'h276, l);
		k = n_ok;
		xfer(`LST_HDR_IMG, 48'h0, 1, 1'b1, 600, n, first, run);
		check(n_ok, k, "partial not shown");
		if (l[2]) begin
			check(n < 600, 1'b1, "partial dropped");
			n = int'((t_drop - t_fall) / 10.0);
			check(in_win(l[1:0], n), 1'b1, "time-out window");
			check(run, last_d, "old image kept");
		end else check(n, 600, "no time-out");
	endtask : tmo

	initial begin
		int n, first, run;
		logic [31:0] r;
		repeat (4) @(posedge clk_i);
		srst_i <= 1'b0;
		@(posedge clk_i);
		#1;
		rel = cyc;
		check(auto, 1'b1, "sync default");
		check(pwm, 3'h0, "pwm after reset");
		i_ctrl.idle(2100);
		img(1'b0);
		cfg(10'h276, 10'h276, 3'h7);
		cfg(10'h27e, 10'h276, 3'h7);
		img(1'b1);
		for (int c = 3; c >= 0; c--) begin
			tmo({1'b1, 2'(c)});
			img(1'b1);
		end
		r = rnd();
		xfer(r[15:0] | 16'h0001, {r, r[15:0]}, 3, 1'b1, 700, n, first, run);
		check(n < 700, 1'b1, "bad header dropped");
		img(1'b1);
		tmo(3'h3);
		@(posedge clk_i);
		srst_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		srst_i <= 1'b0;
		@(posedge clk_i);
		#1;
		check(auto, 1'b1, "sync default again");
		check(pwm, 3'h0, "pwm after second reset");
		stop_test();
	end

	initial begin
		repeat (40000) @(posedge clk_i);
		n_fail++;
		stop_test();
	end
endmodule : lst_link_sync_tb
